// *** rlycfg_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module rlycfg_host (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 resetn_i,
   // Command and reply link
   output logic                      rx_valid_o,
   output logic [7:0]                rx_data_o,
   input  wire logic                 tx_valid_i,
   input  wire logic [7:0]           tx_data_i,
   output logic                      tx_ready_o,
   // Store and relay drivers
   input  wire logic                 nv_req_i,
   input  wire rlycfg_pkg::rlycfg_nv_t   nv_wr_i,
   output logic                      nv_done_o,
   input  wire logic                 bank_send_i,
   input  wire rlycfg_pkg::rlycfg_bank_t bank_i,
   output logic                      bank_done_o
);
   import rlycfg_pkg::*;
   logic [7:0] replies[$];
   rlycfg_nv_t last_nv;
   logic [2:0] nv_wait = 3'h0;
   int         cyc = 0;
   int         last_fire = 0;
   int         gap = 0;
   int         nv_cnt = 0;
   int         nv_cyc = 0;
   int         sends = 0;
   int         max_bank = 0;
   int         max_pass = 0;
   initial begin
      rx_valid_o  = 1'b0;
      rx_data_o   = 8'h00;
      tx_ready_o  = 1'b0;
      nv_done_o   = 1'b0;
      bank_done_o = 1'b0;
   end
   // ==========================================================
   // Bytes go out one per strobe; the idle line shows the inverse
   task automatic send(input logic [7:0] b);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o  <= b;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o  <= ~b;
   endtask
   // ==========================================================
   // Slow side: replies taken every other cycle, store needs 5
   always @(posedge clk_i) begin
      cyc         <= cyc + 1;
      tx_ready_o  <= ~tx_ready_o;
      nv_done_o   <= 1'b0;
      bank_done_o <= bank_send_i;
      if (tx_valid_i && tx_ready_o) begin
         replies.push_back(tx_data_i);
         gap       <= cyc - last_fire;
         last_fire <= cyc;
      end
      if (nv_req_i && !nv_done_o) begin
         nv_wait <= nv_wait + 3'h1;
         if (nv_wait == 3'h4) begin
            nv_done_o <= 1'b1;
            nv_wait   <= 3'h0;
            nv_cnt    <= nv_cnt + 1;
            nv_cyc    <= cyc;
            last_nv   <= nv_wr_i;
         end
      end
      if (bank_send_i) begin
         sends <= sends + 1;
         if (int'(bank_i.bank) > max_bank)
            max_bank <= int'(bank_i.bank);
         if (int'(bank_i.pass) > max_pass)
            max_pass <= int'(bank_i.pass);
      end
   end
endmodule
`default_nettype wire

// *** rlycfg_pkg.sv ***
`default_nettype none
package rlycfg_pkg;
   // ==========================================================
   // Command bytes
   localparam logic [7:0] CMD_ENTRY        = 8'hFE;
   localparam logic [7:0] CMD_SETUP_GROUP  = 8'h32;
   localparam logic [7:0] SUB_READ_REPS    = 8'h88;
   localparam logic [7:0] SUB_SET_REPS     = 8'h89;
   localparam logic [7:0] SUB_READ_SPACING = 8'h8A;
   localparam logic [7:0] SUB_SET_SPACING  = 8'h8B;
   localparam logic [7:0] SUB_READ_BANKS   = 8'h8C;
   localparam logic [7:0] SUB_SET_BANKS    = 8'h8D;
   localparam logic [7:0] SUB_SAFE_PARAMS  = 8'h93;
   localparam logic [7:0] ACK_BYTE         = 8'h55;
   // ==========================================================
   // Settings: reset values and limits
   localparam logic [7:0] REPS_RESET       = 8'h01;
   localparam logic [7:0] SPACING_RESET    = 8'h23;
   localparam logic [7:0] SPACING_MIN      = 8'h03;
   localparam logic [7:0] BANKS_RESET      = 8'h20;
   localparam logic [7:0] BANKS_MAX        = 8'h20;
   // ==========================================================
   // Timing: one spacing step, in ns, and its length in cycles
   localparam int CLK_PERIOD_NS    = 25;
   localparam int SPACE_UNIT_NS    = 10000;
   localparam int SPACE_UNIT_CYC   =
      (SPACE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================================
   // Non-volatile slots
   localparam logic [1:0] NV_SLOT_REPS     = 2'h0;
   localparam logic [1:0] NV_SLOT_SPACING  = 2'h1;
   localparam logic [1:0] NV_SLOT_BANKS    = 2'h2;
   // ==========================================================
   // APB register map (byte addresses)
   localparam logic [7:0] REG_CTRL         = 8'h00;
   localparam logic [7:0] REG_STATUS       = 8'h04;
   localparam logic [7:0] REG_REPS         = 8'h08;
   localparam logic [7:0] REG_SPACING      = 8'h0C;
   localparam logic [7:0] REG_BANKS        = 8'h10;
   localparam int         CTRL_REPORT_BIT  = 0;
   localparam logic       CTRL_RESET       = 1'b1;
   localparam int         STAT_CONFIG_BIT  = 0;
   localparam int         STAT_UPD_BIT     = 1;
   localparam int         STAT_CMD_BIT     = 2;
   // ==========================================================
   typedef struct packed {
      logic [1:0] slot;
      logic [7:0] value;
   } rlycfg_nv_t;
   typedef struct packed {
      logic [4:0] bank;
      logic [7:0] pass;
   } rlycfg_bank_t;
endpackage
`default_nettype wire

// *** rlycfg_top.sv ***
// Operation
// - Commands arrive as entry byte, setup-group byte, sub-command, parameters.
// - Sub-command 137 takes one byte 1..255 as refresh repetition count.
// - Each relay update sends bank data repetition-count times.
// - Refresh repetition count is 1 after reset.
// - Count set in configuration mode is also saved to non-volatile memory.
// - Sub-command 136 replies with the current repetition count.
// - Sub-command 147 restores all key settings to safe values.
// - With reporting on, set and recovery commands answer byte 85.
// - Reply bytes are separated by the byte spacing gap, default 35.
// - Byte spacing never falls below 3.
// - Sub-command 139 takes a spacing byte, saved in configuration mode.
// - In runtime mode spacing set is ignored and answered with 85.
// - Configuration mode always uses spacing 35 for replies.
// - Sub-command 138 replies with the stored byte spacing.
// - Sub-command 141 takes the attached bank count, valid 1..32.
// - Attached bank count is set only in configuration mode.
// - Relay updates cover only banks below the attached count.
// - Sub-command 140 replies with attached bank count, 32 after reset.
// - All setting switches off at power-up means configuration mode.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rlycfg_top #(
   parameter int SW_BITS = 4
) (
   // Clock and reset
   input  wire logic                  core_clk_i,
   input  wire logic                  resetn_i,
   // Setting switches (pins)
   input  wire logic [SW_BITS-1:0]    switches_i,
   // Received command bytes
   input  wire logic                  rx_valid_i,
   input  wire logic [7:0]            rx_data_i,
   // Reply byte transmitter
   output logic                       tx_valid_o,
   output logic [7:0]                 tx_data_o,
   input  wire logic                  tx_ready_i,
   // Non-volatile store
   output logic                       nv_req_o,
   output rlycfg_pkg::rlycfg_nv_t     nv_wr_o,
   input  wire logic                  nv_done_i,
   // Relay bank update loop
   input  wire logic                  upd_req_i,
   output logic                       upd_busy_o,
   output logic                       bank_send_o,
   output rlycfg_pkg::rlycfg_bank_t   bank_o,
   input  wire logic                  bank_done_i,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr
);
   import rlycfg_pkg::*;

   if (SW_BITS < 1 || SW_BITS > 16) begin : g_sw_bits_check
      $error("SW_BITS out of range");
   end

   // ==========================================================
   // Mode strap
   logic [SW_BITS-1:0] sw_meta;
   logic [SW_BITS-1:0] sw_sync;
   logic               strap_done;
   logic               config_mode;

   always_ff @(posedge core_clk_i) begin
      sw_meta <= switches_i;
      sw_sync <= sw_meta;
   end

   // Caught once after reset release; later switch moves are ignored
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         strap_done  <= 1'b0;
         config_mode <= 1'b0;
      end else if (!strap_done) begin
         strap_done  <= 1'b1;
         config_mode <= (sw_sync == '0);
      end
   end

   // ==========================================================
   // Spacing tick divider
   localparam int TICK_W = $clog2(SPACE_UNIT_CYC + 1);
   localparam logic [TICK_W-1:0] TICK_LAST =
      TICK_W'(SPACE_UNIT_CYC - 1);
   logic [TICK_W-1:0] tick_cnt;
   wire               tick = (tick_cnt == TICK_LAST);

   always_ff @(posedge core_clk_i) begin
      // Restarted by each sent byte so no gap comes out a part step short
      if (!resetn_i || tick || (tx_valid_o && tx_ready_i)) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   // ==========================================================
   // Command parser
   typedef enum {
      S_ENTRY, S_GROUP, S_SUB, S_PARAM, S_APPLY, S_SAVE, S_REPLY
   } rlycfg_state_t;

   rlycfg_state_t state;
   logic [7:0]    sub_cmd;
   logic [7:0]    param;
   logic [7:0]    reps;
   logic [7:0]    spacing;
   logic [7:0]    banks;
   logic          report_en;
   logic          reply_pend;
   logic [7:0]    reply_byte;
   logic [7:0]    gap_cnt;

   wire tx_fire   = tx_valid_o && tx_ready_i;
   wire reply_now = reply_pend && (gap_cnt == 8'h00);
   wire has_param = (sub_cmd == SUB_SET_REPS) ||
                    (sub_cmd == SUB_SET_SPACING) ||
                    (sub_cmd == SUB_SET_BANKS);
   wire is_read   = (sub_cmd == SUB_READ_REPS) ||
                    (sub_cmd == SUB_READ_SPACING) ||
                    (sub_cmd == SUB_READ_BANKS);
   wire known_sub = has_param || is_read ||
                    (sub_cmd == SUB_SAFE_PARAMS);
   wire reps_ok   = (param != 8'h00);
   wire banks_ok  = (param != 8'h00) && (param <= BANKS_MAX);
   // Values below the floor are raised to it rather than refused
   wire [7:0] spacing_new = (param < SPACING_MIN) ?
                            SPACING_MIN : param;
   wire do_reps    = (state == S_APPLY) &&
                     (sub_cmd == SUB_SET_REPS) && reps_ok;
   wire do_spacing = (state == S_APPLY) && config_mode &&
                     (sub_cmd == SUB_SET_SPACING);
   wire do_banks   = (state == S_APPLY) && config_mode &&
                     (sub_cmd == SUB_SET_BANKS) && banks_ok;
   wire do_safe    = (state == S_APPLY) &&
                     (sub_cmd == SUB_SAFE_PARAMS);
   wire need_save  = config_mode && (do_reps || do_spacing || do_banks);
   // Runtime spacing set answers 85 even with reporting off
   wire spacing_rt = !config_mode && (sub_cmd == SUB_SET_SPACING);
   wire send_ack   = report_en || spacing_rt;

   logic [7:0] read_value;
   always_comb begin
      case (sub_cmd)
         SUB_READ_REPS:    read_value = reps;
         SUB_READ_SPACING: read_value = spacing;
         SUB_READ_BANKS:   read_value = banks;
         default:          read_value = ACK_BYTE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state   <= S_ENTRY;
         sub_cmd <= 8'h00;
         param   <= 8'h00;
      end else begin
         case (state)
            S_ENTRY: begin
               if (rx_valid_i && rx_data_i == CMD_ENTRY) begin
                  state <= S_GROUP;
               end
            end
            S_GROUP: begin
               if (rx_valid_i) begin
                  state <= (rx_data_i == CMD_SETUP_GROUP) ?
                           S_SUB : S_ENTRY;
               end
            end
            S_SUB: begin
               if (rx_valid_i) begin
                  sub_cmd <= rx_data_i;
                  state   <= S_PARAM;
               end
            end
            S_PARAM: begin
               if (!known_sub) begin
                  state <= S_ENTRY;
               end else if (!has_param) begin
                  state <= S_APPLY;
               end else if (rx_valid_i) begin
                  param <= rx_data_i;
                  state <= S_APPLY;
               end
            end
            S_APPLY: begin
               if (need_save) begin
                  state <= S_SAVE;
               end else if (is_read || send_ack) begin
                  state <= S_REPLY;
               end else begin
                  state <= S_ENTRY;
               end
            end
            S_SAVE: begin
               if (nv_done_i) begin
                  state <= report_en ? S_REPLY : S_ENTRY;
               end
            end
            S_REPLY: begin
               if (!reply_pend) begin
                  state <= S_ENTRY;
               end
            end
            default: state <= S_ENTRY;
         endcase
      end
   end

   // ==========================================================
   // Settings
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || do_safe) begin
         reps    <= REPS_RESET;
         spacing <= SPACING_RESET;
         banks   <= BANKS_RESET;
      end else begin
         if (do_reps) begin
            reps <= param;
         end
         if (do_spacing) begin
            spacing <= spacing_new;
         end
         if (do_banks) begin
            banks <= param;
         end
      end
   end

   // Save request holds until the store reports completion
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         nv_req_o <= 1'b0;
         nv_wr_o  <= '0;
      end else if (need_save && state == S_APPLY) begin
         nv_req_o      <= 1'b1;
         nv_wr_o.value <= do_spacing ? spacing_new : param;
         nv_wr_o.slot  <= do_reps ? NV_SLOT_REPS :
                          do_spacing ? NV_SLOT_SPACING : NV_SLOT_BANKS;
      end else if (nv_done_i) begin
         nv_req_o <= 1'b0;
      end
   end

   // ==========================================================
   // Reply transmitter with inter-byte gap
   wire [7:0] gap_load = config_mode ? SPACING_RESET : spacing;

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         reply_pend <= 1'b0;
         reply_byte <= 8'h00;
      end else if (state == S_APPLY && !need_save &&
                   (is_read || send_ack)) begin
         reply_pend <= 1'b1;
         reply_byte <= is_read ? read_value : ACK_BYTE;
      end else if (state == S_SAVE && nv_done_i && report_en) begin
         reply_pend <= 1'b1;
         reply_byte <= ACK_BYTE;
      end else if (tx_fire) begin
         reply_pend <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         gap_cnt <= 8'h00;
      end else if (tx_fire) begin
         gap_cnt <= gap_load;
      end else if (tick && gap_cnt != 8'h00) begin
         gap_cnt <= gap_cnt - 8'h01;
      end
   end

   assign tx_valid_o = reply_now;
   assign tx_data_o  = reply_byte;

   // ==========================================================
   // Relay bank update loop
   typedef enum {U_IDLE, U_SEND, U_WAIT} rlycfg_upd_t;
   rlycfg_upd_t upd_state;
   logic [4:0]  bank_idx;
   logic [7:0]  pass_idx;
   wire last_bank = ({3'b000, bank_idx} == banks - 8'h01);
   wire last_pass = (pass_idx == reps - 8'h01);

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         upd_state <= U_IDLE;
         bank_idx  <= 5'h00;
         pass_idx  <= 8'h00;
      end else begin
         case (upd_state)
            U_IDLE: begin
               if (upd_req_i) begin
                  upd_state <= U_SEND;
                  bank_idx  <= 5'h00;
                  pass_idx  <= 8'h00;
               end
            end
            U_SEND: upd_state <= U_WAIT;
            U_WAIT: begin
               if (bank_done_i) begin
                  upd_state <= U_SEND;
                  if (!last_bank) begin
                     bank_idx <= bank_idx + 5'h01;
                  end else begin
                     bank_idx <= 5'h00;
                     pass_idx <= pass_idx + 8'h01;
                     if (last_pass) begin
                        upd_state <= U_IDLE;
                     end
                  end
               end
            end
            default: upd_state <= U_IDLE;
         endcase
      end
   end

   assign upd_busy_o  = (upd_state != U_IDLE);
   assign bank_send_o = (upd_state == U_SEND);
   assign bank_o      = '{bank: bank_idx, pass: pass_idx};

   // ==========================================================
   // APB register file
   wire setup   = psel && !penable;
   wire wr_acc  = psel && penable && pwrite;
   wire hit_ctl = (paddr == REG_CTRL);
   wire mapped  = hit_ctl || (paddr == REG_STATUS) ||
                  (paddr == REG_REPS) || (paddr == REG_SPACING) ||
                  (paddr == REG_BANKS);
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         REG_CTRL:    rd_mux[CTRL_REPORT_BIT] = report_en;
         REG_STATUS: begin
            rd_mux[STAT_CONFIG_BIT] = config_mode;
            rd_mux[STAT_UPD_BIT]    = upd_busy_o;
            rd_mux[STAT_CMD_BIT]    = (state != S_ENTRY);
         end
         REG_REPS:    rd_mux[7:0] = reps;
         REG_SPACING: rd_mux[7:0] = spacing;
         REG_BANKS:   rd_mux[7:0] = banks;
         default:     rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         report_en <= CTRL_RESET;
         prdata    <= 32'h0000_0000;
      end else begin
         if (setup) begin
            prdata <= rd_mux;
         end
         if (wr_acc && hit_ctl) begin
            report_en <= pwdata[CTRL_REPORT_BIT];
         end
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ==========================================================
   // Checks
   property p_reps_reset;
      @(posedge core_clk_i) !resetn_i |=> reps == REPS_RESET;
   endproperty
   a_reps_reset: assert property (p_reps_reset)
      else $error("repetition count not 1 after reset");

   property p_spacing_floor;
      @(posedge core_clk_i) disable iff (!resetn_i)
         spacing >= SPACING_MIN;
   endproperty
   a_spacing_floor: assert property (p_spacing_floor)
      else $error("byte spacing below floor");

   property p_banks_range;
      @(posedge core_clk_i) disable iff (!resetn_i)
         banks != 8'h00 && banks <= BANKS_MAX;
   endproperty
   a_banks_range: assert property (p_banks_range)
      else $error("attached bank count out of range");

   property p_banks_locked;
      @(posedge core_clk_i) disable iff (!resetn_i)
         (!config_mode && strap_done && !do_safe) |=> $stable(banks);
   endproperty
   a_banks_locked: assert property (p_banks_locked)
      else $error("bank count changed in runtime mode");

   property p_bank_limit;
      @(posedge core_clk_i) disable iff (!resetn_i)
         bank_send_o |-> ({3'b000, bank_o.bank} < banks &&
                          bank_o.pass < reps);
   endproperty
   a_bank_limit: assert property (p_bank_limit)
      else $error("bank send beyond attached count or passes");

   property p_gap_after_byte;
      @(posedge core_clk_i) disable iff (!resetn_i)
         tx_fire |=> !tx_valid_o [*2];
   endproperty
   a_gap_after_byte: assert property (p_gap_after_byte)
      else $error("reply bytes sent without gap");

   property p_config_gap;
      @(posedge core_clk_i) disable iff (!resetn_i)
         (tx_fire && config_mode) |=> gap_cnt == SPACING_RESET;
   endproperty
   a_config_gap: assert property (p_config_gap)
      else $error("configuration mode gap not fixed");

   property p_ack_after_save;
      @(posedge core_clk_i) disable iff (!resetn_i)
         nv_req_o |-> !reply_pend;
   endproperty
   a_ack_after_save: assert property (p_ack_after_save)
      else $error("acknowledge queued before save done");

   property p_runtime_spacing_ack;
      @(posedge core_clk_i) disable iff (!resetn_i)
         (state == S_APPLY && spacing_rt) |=>
            reply_pend && reply_byte == ACK_BYTE && $stable(spacing);
   endproperty
   a_runtime_spacing_ack: assert property (p_runtime_spacing_ack)
      else $error("runtime spacing set not refused with 85");

   property p_read_reps;
      @(posedge core_clk_i) disable iff (!resetn_i)
         (state == S_APPLY && sub_cmd == SUB_READ_REPS) |=>
            reply_byte == $past(reps);
   endproperty
   a_read_reps: assert property (p_read_reps)
      else $error("repetition read reply wrong");

   property p_update_starts;
      @(posedge core_clk_i) disable iff (!resetn_i)
         (upd_state == U_IDLE && upd_req_i) |=> bank_send_o ##1 upd_busy_o;
   endproperty
   a_update_starts: assert property (p_update_starts)
      else $error("relay update did not start");
endmodule
`default_nettype wire

// *** rlycfg_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module rlycfg_top_tb;
   import rlycfg_pkg::*;
   logic         core_clk_i = 1'b0;
   logic         resetn_i = 1'b0;
   logic [3:0]   switches_i = 4'h0;
   logic         upd_req_i = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h00000000;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic         rx_valid, tx_valid, tx_ready, nv_req, nv_done;
   logic         upd_busy, bank_send, bank_done;
   logic [7:0]   rx_data, tx_data;
   rlycfg_nv_t   nv_wr;
   rlycfg_bank_t bank;
   logic [31:0]  rd;
   logic         err;
   int           miscompares = 0;
   int           checks_done = 0;
   int           cycles = 0;
   always #12.5 core_clk_i = ~core_clk_i;
   rlycfg_top #(.SW_BITS(4)) i_dut (.core_clk_i(core_clk_i),
      .resetn_i(resetn_i), .switches_i(switches_i),
      .rx_valid_i(rx_valid), .rx_data_i(rx_data),
      .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
      .nv_req_o(nv_req), .nv_wr_o(nv_wr), .nv_done_i(nv_done),
      .upd_req_i(upd_req_i), .upd_busy_o(upd_busy),
      .bank_send_o(bank_send), .bank_o(bank), .bank_done_i(bank_done),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   rlycfg_host i_host (.clk_i(core_clk_i), .resetn_i(resetn_i),
      .rx_valid_o(rx_valid), .rx_data_o(rx_data), .tx_valid_i(tx_valid),
      .tx_data_i(tx_data), .tx_ready_o(tx_ready), .nv_req_i(nv_req),
      .nv_wr_i(nv_wr), .nv_done_o(nv_done), .bank_send_i(bank_send),
      .bank_i(bank), .bank_done_o(bank_done));
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e,
                      input string m);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %0t %s: saw %h expected %h", $time, m, s, e);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic do_reset(input logic [3:0] sw);
      switches_i <= sw;
      resetn_i   <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk_i);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      @(posedge core_clk_i);
      while (pready !== 1'b1) @(posedge core_clk_i);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                        input string m);
      apb(1'b0, a, 32'h00000000);
      chk(rd, e, m);
   endtask
   // Parser busy ends once the reply byte is sent; the reply gap is kept by the transmitter, not here
   task automatic cmd(input logic [7:0] sub, input logic np,
                      input logic [7:0] prm);
      i_host.send(CMD_ENTRY);
      i_host.send(CMD_SETUP_GROUP);
      i_host.send(sub);
      if (np)
         i_host.send(prm);
      do apb(1'b0, REG_STATUS, 32'h00000000);
      while (rd[STAT_CMD_BIT] !== 1'b0);
   endtask
   task automatic got(input logic [7:0] e, input string m);
      chk(32'(i_host.replies.size()), 32'h00000001, m);
      if (i_host.replies.size() > 0)
         chk({24'h000000, i_host.replies.pop_front()}, {24'h000000, e}, m);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_defaults();
      rdchk(REG_REPS, 32'h00000001, "reps reset");
      rdchk(REG_SPACING, 32'h00000023, "spacing reset");
      rdchk(REG_BANKS, 32'h00000020, "banks reset");
      rdchk(REG_STATUS, 32'h00000001, "config mode");
      apb(1'b0, 8'h14, 32'h00000000);
      chk({31'h0, err}, 32'h00000001, "unmapped");
      cmd(SUB_READ_REPS, 1'b0, 8'h00);
      got(8'h01, "read reps");
      $display("t_defaults done");
   endtask
   task automatic t_set_cfg();
      int nv0;
      nv0 = i_host.nv_cnt;
      cmd(SUB_SET_REPS, 1'b1, 8'hFF);
      got(ACK_BYTE, "reps ack");
      chk(32'(i_host.last_fire > i_host.nv_cyc), 32'h1, "ack order");
      chk(32'(i_host.nv_cnt - nv0), 32'h00000001, "reps saved");
      chk({22'h0, i_host.last_nv}, {22'h0, NV_SLOT_REPS, 8'hFF}, "nv");
      rdchk(REG_REPS, 32'h000000FF, "reps 255");
      apb(1'b1, REG_CTRL, 32'h00000000);
      cmd(SUB_SET_REPS, 1'b1, 8'h00);
      rdchk(REG_REPS, 32'h000000FF, "reps 0 kept");
      cmd(SUB_SET_REPS, 1'b1, 8'h02);
      cmd(SUB_SET_SPACING, 1'b1, 8'h01);
      rdchk(REG_SPACING, 32'h00000003, "spacing floor");
      chk({22'h0, i_host.last_nv}, {22'h0, NV_SLOT_SPACING, 8'h03}, "nv");
      cmd(SUB_SET_BANKS, 1'b1, 8'h00);
      cmd(SUB_SET_BANKS, 1'b1, 8'h21);
      rdchk(REG_BANKS, 32'h00000020, "banks bad kept");
      cmd(SUB_SET_BANKS, 1'b1, 8'h03);
      rdchk(REG_BANKS, 32'h00000003, "banks 3");
      $display("t_set_cfg done");
   endtask
   task automatic t_read_cfg();
      cmd(SUB_READ_SPACING, 1'b0, 8'h00);
      got(8'h03, "read spacing");
      cmd(SUB_READ_BANKS, 1'b0, 8'h00);
      got(8'h03, "read banks");
      chk(32'(i_host.gap >= 35 * SPACE_UNIT_CYC), 32'h1, "gap");
      $display("t_read_cfg done");
   endtask
   task automatic t_update();
      int s0;
      s0 = i_host.sends;
      i_host.max_bank = 0;
      i_host.max_pass = 0;
      upd_req_i <= 1'b1;
      @(posedge core_clk_i);
      upd_req_i <= 1'b0;
      @(posedge core_clk_i);
      while (upd_busy !== 1'b0) @(posedge core_clk_i);
      chk(32'(i_host.sends - s0), 32'h00000006, "sends");
      chk(32'(i_host.max_bank), 32'h00000002, "last bank");
      chk(32'(i_host.max_pass), 32'h00000001, "last pass");
      $display("t_update done");
   endtask
   task automatic t_safe();
      apb(1'b1, REG_CTRL, 32'h00000001);
      cmd(SUB_SAFE_PARAMS, 1'b0, 8'h00);
      got(ACK_BYTE, "safe ack");
      rdchk(REG_REPS, 32'h00000001, "safe reps");
      rdchk(REG_SPACING, 32'h00000023, "safe spacing");
      rdchk(REG_BANKS, 32'h00000020, "safe banks");
      $display("t_safe done");
   endtask
   task automatic t_runtime();
      int nv0;
      do_reset(4'h1);
      rdchk(REG_STATUS, 32'h00000000, "runtime mode");
      apb(1'b1, REG_CTRL, 32'h00000000);
      nv0 = i_host.nv_cnt;
      cmd(SUB_SET_SPACING, 1'b1, 8'h0A);
      got(ACK_BYTE, "runtime ack");
      rdchk(REG_SPACING, 32'h00000023, "spacing kept");
      cmd(SUB_SET_BANKS, 1'b1, 8'h04);
      rdchk(REG_BANKS, 32'h00000020, "banks kept");
      cmd(SUB_SET_REPS, 1'b1, 8'h05);
      rdchk(REG_REPS, 32'h00000005, "reps volatile");
      chk(32'(i_host.nv_cnt - nv0), 32'h00000000, "no save");
      $display("t_runtime done");
   endtask
   // ==========================================================
   initial begin
      do_reset(4'h0);
      t_defaults();
      t_set_cfg();
      t_read_cfg();
      t_update();
      t_safe();
      t_runtime();
      complete_run();
   end
   // Four reply gaps of 14000 cycles dominate the run
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         miscompares++;
         complete_run();
      end
   end
endmodule
`default_nettype wire
